// file: verilog/sbc_consts.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: included by bare name
// Notes: register words are 32 bits, aligned
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH
`define SBC_OFS_CTRL 4'h0
`define SBC_OFS_STAT 4'h4
`define SBC_OFS_PER 4'h8
`define SBC_CTRL_DIR 0
`define SBC_CTRL_LEAD_LO 1
`define SBC_CTRL_LAP 3
`define SBC_CTRL_RST 4'h8
`define SBC_RESON_MHZ 10
`define SBC_FORCED_DIV 17
`define SBC_SAMPLE_CYC 10'h200
`define SBC_PWM_HIGH_NS 250
`define SBC_LOCK_EDGES 2'h2
`endif

// file: verilog/sbc_pkg.sv
// Purpose: shared types of the commutator
// Assumes: nothing
// Notes: mode codes are one-hot
package sbc_pkg;
   typedef enum logic [2:0]
   {
      SBC_STOP = 3'b001,
      SBC_FORCED = 3'b010,
      SBC_NORMAL = 3'b100
   } sbc_mode_type;
   typedef logic [1:0] sbc_lead_type;
endpackage

// file: verilog/sbc_commutator.sv
// Purpose: sensorless three-phase commutator with wishbone control
// Assumes: clk_i is the resonator clock, inputs synchronous to it
// Notes: ctrl 0x0, status 0x4, period 0x8
// What this block does, and what it expects of the pwm source
// [RULE1] lead angle 0, 7.5, 15, 30 from two bits
// [RULE2] pwm input active low gates turn-on outputs; here it gates the upper outputs only, lower outputs stay on
// [RULE3] source never holds pwm low, high >=250ns
// [RULE4] direction high reverse UWV, low forward UVW
// [RULE5] frequency output follows u phase, unchopped
// [RULE6] lap select high 120 degrees, low overlap
// [RULE7] forced start step from 6 x 2^17 divider
// [RULE8] upper outputs low switch winding on
// [RULE9] lower outputs high switch winding on
// [RULE10] overcurrent high suppresses pwm-driven pulses
// [RULE11] rotor position from single combined input
// [RULE12] forced start uses 0 degrees unless 30
// [RULE13] position sampled on pwm falling edges
// [RULE14] two 512-cycle samples start or stop
// [RULE15] forced steps until position edges, then normal
// [RULE16] one upper, one lower, six steps
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`include "sbc_consts.svh"
module sbc_commutator #(
   parameter int FORCED_STEP_CYCLES = 131072,
   parameter int PER_W = 20
)(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic err_o,
   // motor side inputs
   input wire logic pwm_n_i,
   input wire logic overcurrent_in_i,
   input wire logic position_in_i,
   // phase drives and rotation frequency output
   output logic phase_u_high_drive_n_o,
   output logic phase_u_low_drive_o,
   output logic phase_v_high_drive_n_o,
   output logic phase_v_low_drive_o,
   output logic phase_w_high_drive_n_o,
   output logic phase_w_low_drive_o,
   output logic rotation_freq_out_o
);
   import sbc_pkg::*;

   localparam logic [17:0] FORCED_LAST = 18'(FORCED_STEP_CYCLES - 1);

   sbc_mode_type mode_ff;
   logic direction_select_ff;
   sbc_lead_type lead_sel_ff;
   logic lap_sel_ff;
   logic [2:0] step_ff;
   logic [5:0] prev_drv_ff;
   logic [PER_W-1:0] lap_cnt_ff;
   logic [17:0] forced_cnt_ff;
   logic [9:0] smp_cnt_ff;
   logic saw_on_ff;
   logic last_det_ff;
   logic det_valid_ff;
   logic pwm_prev_ff;
   logic pos_ff;
   logic [1:0] edges_ff;
   logic [PER_W-1:0] per_cnt_ff;
   logic [PER_W-1:0] period_ff;
   logic [PER_W-1:0] delay_ff;
   logic pending_ff;
   logic ack_ff;
   logic err_ff;
   logic [31:0] dat_ff;
   logic [5:0] drv_ff;
   logic rfo_ff;

   logic pwm_on;
   logic pwm_fall;
   logic pos_edge;
   logic smp_tick;
   logic step_now;
   logic wb_req;
   sbc_lead_type eff_lead;
   logic [PER_W-1:0] nxt_delay;
   logic [5:0] cur_drv;
   logic [5:0] all_drv;

   // step table: {upper w,v,u, lower w,v,u}
   function automatic logic [5:0] sbc_step_drv(input logic [2:0] s);
      logic [5:0] d;
      d = 6'h00;
      case (s)
         3'd0: d = 6'b001_010;
         3'd1: d = 6'b001_100;
         3'd2: d = 6'b010_100;
         3'd3: d = 6'b010_001;
         3'd4: d = 6'b100_001;
         3'd5: d = 6'b100_010;
         default: d = 6'h00;
      endcase
      return d;
   endfunction

   assign pwm_on = ~pwm_n_i; // [RULE2]
   assign pwm_fall = pwm_prev_ff & pwm_n_i == 1'b0; // [RULE13]
   assign smp_tick = (smp_cnt_ff == `SBC_SAMPLE_CYC - 10'h1);
   // a lead of 30 holds even during forced start
   assign eff_lead = (mode_ff == SBC_NORMAL || lead_sel_ff == 2'h3) ? lead_sel_ff : 2'h0; // [RULE12]
   assign wb_req = cyc_i & stb_i & ~ack_ff & ~err_ff;

   // delay from zero cross: 30 deg minus lead, period is 60 deg
   always_comb
   begin
      case (eff_lead) // [RULE1]
         2'h0: nxt_delay = period_ff >> 1;
         2'h1: nxt_delay = (period_ff >> 2) + (period_ff >> 3);
         2'h2: nxt_delay = period_ff >> 2;
         default: nxt_delay = '0;
      endcase
   end

   // position input is already the majority of the three terminals
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pwm_prev_ff <= 1'b1;
         pos_ff <= 1'b0;
      end
      else
      begin
         pwm_prev_ff <= pwm_n_i;
         if (pwm_fall)
            pos_ff <= position_in_i; // [RULE11] [RULE13]
      end
   end
   assign pos_edge = pwm_fall & (position_in_i != pos_ff) & (mode_ff != SBC_STOP);

   // start/stop sampler; any on-time in a window counts as drive-on
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         smp_cnt_ff <= 10'h0;
         saw_on_ff <= 1'b0;
         last_det_ff <= 1'b0;
         det_valid_ff <= 1'b0;
      end
      else
      begin
         smp_cnt_ff <= smp_tick ? 10'h0 : smp_cnt_ff + 10'h1;
         if (smp_tick)
         begin
            saw_on_ff <= pwm_on;
            last_det_ff <= saw_on_ff | pwm_on; // [RULE14]
            det_valid_ff <= 1'b1;
         end
         else if (pwm_on)
            saw_on_ff <= 1'b1;
      end
   end

   // mode machine
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mode_ff <= SBC_STOP;
      else
      begin
         case (mode_ff)
            SBC_STOP:
               if (smp_tick && det_valid_ff && last_det_ff && (saw_on_ff | pwm_on))
                  mode_ff <= SBC_FORCED; // [RULE14]
            SBC_FORCED:
               if (smp_tick && det_valid_ff && !last_det_ff && !(saw_on_ff | pwm_on))
                  mode_ff <= SBC_STOP; // [RULE14]
               else if (pos_edge && edges_ff == `SBC_LOCK_EDGES - 2'h1)
                  mode_ff <= SBC_NORMAL; // [RULE15]
            SBC_NORMAL:
               if (smp_tick && det_valid_ff && !last_det_ff && !(saw_on_ff | pwm_on))
                  mode_ff <= SBC_STOP; // [RULE14]
               else if (&per_cnt_ff)
                  mode_ff <= SBC_FORCED; // lost position, restart forced
            default: mode_ff <= SBC_STOP;
         endcase
      end
   end

   // position edge counting and period measure
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         edges_ff <= 2'h0;
         per_cnt_ff <= '0;
         period_ff <= '0;
      end
      // lost position restarts the lock count, else forced mode never relocks
      else if (mode_ff == SBC_STOP || &per_cnt_ff)
      begin
         edges_ff <= 2'h0;
         per_cnt_ff <= '0;
      end
      else if (pos_edge)
      begin
         if (edges_ff != `SBC_LOCK_EDGES)
            edges_ff <= edges_ff + 2'h1; // [RULE15]
         per_cnt_ff <= '0;
         period_ff <= per_cnt_ff;
      end
      else
         per_cnt_ff <= per_cnt_ff + 1'b1;
   end

   // forced commutation divider, six steps per electrical turn
   always_ff @(posedge clk_i)
   begin
      if (rst_i || mode_ff != SBC_FORCED || forced_cnt_ff == FORCED_LAST)
         forced_cnt_ff <= 18'h0; // [RULE7]
      else
         forced_cnt_ff <= forced_cnt_ff + 18'h1;
   end

   // delayed commutation after a zero cross
   always_ff @(posedge clk_i)
   begin
      if (rst_i || mode_ff != SBC_NORMAL)
      begin
         pending_ff <= 1'b0;
         delay_ff <= '0;
      end
      else if (pos_edge)
      begin
         pending_ff <= 1'b1;
         delay_ff <= nxt_delay; // [RULE1]
      end
      else if (pending_ff && delay_ff != '0)
         delay_ff <= delay_ff - 1'b1;
      else
         pending_ff <= 1'b0;
   end

   assign step_now = (mode_ff == SBC_FORCED && forced_cnt_ff == FORCED_LAST)
      || (mode_ff == SBC_NORMAL && pending_ff && delay_ff == '0); // [RULE15]

   // step index and lap overlap
   always_ff @(posedge clk_i)
   begin
      if (rst_i || mode_ff == SBC_STOP)
      begin
         step_ff <= 3'h0;
         prev_drv_ff <= 6'h00;
         lap_cnt_ff <= '0;
      end
      else if (step_now)
      begin
         if (direction_select_ff)
            step_ff <= (step_ff == 3'h0) ? 3'h5 : step_ff - 3'h1; // [RULE4]
         else
            step_ff <= (step_ff == 3'h5) ? 3'h0 : step_ff + 3'h1; // [RULE4] [RULE16]
         prev_drv_ff <= cur_drv;
         // overlap length is an eighth of the last step time
         if (!lap_sel_ff)
            lap_cnt_ff <= (mode_ff == SBC_NORMAL) ? (period_ff >> 3) : PER_W'(FORCED_STEP_CYCLES / 8); // [RULE6]
         else
            lap_cnt_ff <= '0; // [RULE6]
      end
      else if (lap_cnt_ff != '0)
         lap_cnt_ff <= lap_cnt_ff - 1'b1;
   end

   assign cur_drv = sbc_step_drv(step_ff); // [RULE16]
   assign all_drv = (lap_cnt_ff != '0) ? (cur_drv | prev_drv_ff) : cur_drv; // [RULE6]

   // upper sides carry the chop; lower sides stay on through the step
   always_ff @(posedge clk_i)
   begin
      if (rst_i || mode_ff == SBC_STOP)
      begin
         drv_ff <= 6'h00;
         rfo_ff <= 1'b0;
      end
      else
      begin
         drv_ff[5:3] <= all_drv[5:3] & {3{pwm_on & ~overcurrent_in_i}}; // [RULE2] [RULE10]
         drv_ff[2:0] <= all_drv[2:0];
         rfo_ff <= cur_drv[3]; // [RULE5]
      end
   end

   assign phase_u_high_drive_n_o = ~drv_ff[3]; // [RULE8]
   assign phase_v_high_drive_n_o = ~drv_ff[4]; // [RULE8]
   assign phase_w_high_drive_n_o = ~drv_ff[5]; // [RULE8]
   assign phase_u_low_drive_o = drv_ff[0]; // [RULE9]
   assign phase_v_low_drive_o = drv_ff[1]; // [RULE9]
   assign phase_w_low_drive_o = drv_ff[2]; // [RULE9]
   assign rotation_freq_out_o = rfo_ff;

   // wishbone: one wait state, unmapped answers with err
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_ff <= 1'b0;
         err_ff <= 1'b0;
         dat_ff <= 32'h0;
         direction_select_ff <= 1'b0;
         lead_sel_ff <= 2'h0;
         lap_sel_ff <= 1'b1;
      end
      else
      begin
         ack_ff <= 1'b0;
         err_ff <= 1'b0;
         dat_ff <= 32'h0;
         if (wb_req)
         begin
            if (adr_i == `SBC_OFS_CTRL)
            begin
               ack_ff <= 1'b1;
               if (we_i && sel_i[0])
               begin
                  direction_select_ff <= dat_i[`SBC_CTRL_DIR];
                  lead_sel_ff <= dat_i[`SBC_CTRL_LEAD_LO +: 2];
                  lap_sel_ff <= dat_i[`SBC_CTRL_LAP];
               end
               dat_ff <= {28'h0, lap_sel_ff, lead_sel_ff, direction_select_ff};
            end
            else if (adr_i == `SBC_OFS_STAT)
            begin
               ack_ff <= 1'b1;
               dat_ff <= {23'h0, overcurrent_in_i, eff_lead, step_ff, mode_ff};
            end
            else if (adr_i == `SBC_OFS_PER)
            begin
               ack_ff <= 1'b1;
               dat_ff <= 32'(period_ff);
            end
            else
               err_ff <= 1'b1;
         end
      end
   end
   assign ack_o = ack_ff;
   assign err_o = err_ff;
   assign dat_o = dat_ff;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_overcur_blocks_upper: // [RULE10]
      assert property (overcurrent_in_i |=> &{phase_u_high_drive_n_o, phase_v_high_drive_n_o, phase_w_high_drive_n_o})
      else $error("upper drive on during overcurrent");
   a_pwm_off_upper: // [RULE2]
      assert property (pwm_n_i |=> !(drv_ff[5:3] != 3'h0))
      else $error("upper drive on while pwm off");
   a_one_hi_one_lo: // [RULE16]
      assert property (lap_sel_ff && lap_cnt_ff == '0 && mode_ff != SBC_STOP |-> $onehot(cur_drv[5:3])
         && $onehot(cur_drv[2:0]) && (cur_drv[5:3] & cur_drv[2:0]) == 3'h0)
      else $error("bad step pattern");
   a_dir_order: // [RULE4]
      assert property (step_now && !direction_select_ff && step_ff == 3'h1 |=> step_ff == 3'h2)
      else $error("forward order broken");
   a_rev_order: // [RULE4]
      assert property (step_now && direction_select_ff && step_ff == 3'h0 |=> step_ff == 3'h5)
      else $error("reverse order broken");
   a_freq_unchopped: // [RULE5]
      assert property (mode_ff != SBC_STOP && $stable(step_ff) && $past(mode_ff) != SBC_STOP
         |=> rotation_freq_out_o == $past(cur_drv[3], 2) || $changed(step_ff))
      else $error("frequency output not u phase");
   a_forced_lead_zero: // [RULE12]
      assert property (mode_ff == SBC_FORCED && lead_sel_ff != 2'h3 |-> eff_lead == 2'h0)
      else $error("lead applied during forced start");
   a_forced_period: // [RULE7]
      assert property (step_now && mode_ff == SBC_FORCED ##1 mode_ff == SBC_FORCED [*1]
         |-> forced_cnt_ff == 18'h0)
      else $error("forced divider not restarted");
   a_stop_outputs_off: // [RULE8] [RULE9]
      assert property (mode_ff == SBC_STOP ##1 mode_ff == SBC_STOP |-> drv_ff == 6'h00)
      else $error("outputs on while stopped");
   a_pos_sampled: // [RULE13]
      assert property (!pwm_fall |=> $stable(pos_ff))
      else $error("position sampled off pwm edge");
   a_wb_ack_pulse:
      assert property (ack_o |=> !ack_o)
      else $error("ack held two cycles");

   c_start: cover property (mode_ff == SBC_STOP ##1 mode_ff == SBC_FORCED);
   c_lock: cover property (mode_ff == SBC_FORCED ##1 mode_ff == SBC_NORMAL);
   c_lap: cover property (lap_cnt_ff != '0 && drv_ff != 6'h00);
   c_stop: cover property (mode_ff == SBC_NORMAL ##1 mode_ff == SBC_STOP);
endmodule

// file: bench/sbc_drive_model.sv
// Purpose: pwm source and combined back-emf stand-in for the commutator
// Assumes: clk_i is the resonator clock
// Notes: pwm period 10 cycles, 7 low and 3 high
`timescale 1ns/1ps
module sbc_drive_model #(
   parameter int HALF_TURN = 200
)(
   // clock and control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic spin_i,
   // motor side
   output logic pwm_n_o,
   output logic position_o
);
   int pwm_cnt_ff;
   int pos_cnt_ff;
   always_ff @(posedge clk_i)
   begin
      if (rst_i || pwm_cnt_ff == 9)
         pwm_cnt_ff <= 0;
      else
         pwm_cnt_ff <= pwm_cnt_ff + 1;
   end
   // 300 ns high each period, idles high like the pull-up
   assign pwm_n_o = !(run_i && pwm_cnt_ff < 7);
   // level holds between zero crosses, as a comparator would
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pos_cnt_ff <= 0;
         position_o <= 1'b0;
      end
      else if (spin_i)
      begin
         pos_cnt_ff <= (pos_cnt_ff == HALF_TURN - 1) ? 0 : pos_cnt_ff + 1;
         if (pos_cnt_ff == HALF_TURN - 1)
            position_o <= !position_o;
      end
   end
endmodule

// file: bench/test_sbc_commutator.sv
// Purpose: self-checking bench for the commutator
// Assumes: short forced step of 64 cycles, period width 10
// Notes: bus rows first, motor scenarios after
`timescale 1ns/1ps
`include "sbc_consts.svh"
module test_sbc_commutator;
   import sbc_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ovc = 0, run = 0, spin = 0;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] wdat = 32'h0, q, dat_o;
   logic e, ack_o, err_o, pwm_n, pos, fq, un, ul, vn, vl, wn, wl;
   int fail_count = 0, samples_checked = 0, cycles = 0;
   logic [3:0] r_adr [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h8, 4'hc};
   logic [3:0] r_sel [8] = '{4'hf, 4'hf, 4'hf, 4'he, 4'hf, 4'hf, 4'hf, 4'hf};
   logic [31:0] r_dat [8] = '{32'ha, 32'hc, 32'he, 32'h1, 32'h8, 32'hff, 32'hff, 32'h0};
   logic [31:0] r_exp [8] = '{32'ha, 32'hc, 32'he, 32'he, 32'h8, 32'h1, 32'h0, 32'h0};
   sbc_commutator #(.FORCED_STEP_CYCLES(64), .PER_W(10)) sbc_commutator_inst (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
      .err_o(err_o), .pwm_n_i(pwm_n), .overcurrent_in_i(ovc), .position_in_i(pos), .phase_u_high_drive_n_o(un),
      .phase_u_low_drive_o(ul), .phase_v_high_drive_n_o(vn), .phase_v_low_drive_o(vl),
      .phase_w_high_drive_n_o(wn), .phase_w_low_drive_o(wl), .rotation_freq_out_o(fq));
   sbc_drive_model sbc_drive_model_inst (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .spin_i(spin),
      .pwm_n_o(pwm_n), .position_o(pos));
   initial
   begin
      forever #50 clk_i = !clk_i;
   end
   task automatic conclude();
      $display("checked %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // request held until ack or err seen, then released
   task automatic wb(input logic [3:0] a, input logic w, input logic [3:0] s, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1; stb <= 1; adr <= a; we <= w; sel <= s; wdat <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1 && err_o !== 1 && n < 50);
      q = dat_o;
      e = err_o;
      if (ack_o !== 1 && err_o !== 1)
         chk(32'h0, 32'h1);
      cyc <= 0; stb <= 0; we <= 0;
      @(posedge clk_i);
   endtask
   task automatic wait_mode(input logic [2:0] m);
      int n;
      n = 0;
      do
      begin
         wb(4'h4, 0, 4'hf, 32'h0);
         n++;
      end
      while (q[2:0] !== m && n < 600);
      chk(q[2:0], m);
   endtask
   // steps one forced interval apart: the 60 idle cycles plus bus overhead make 64
   task automatic step_by(input int inc);
      logic [2:0] s0;
      wb(4'h4, 0, 4'hf, 32'h0);
      s0 = q[5:3];
      repeat (60) @(posedge clk_i);
      wb(4'h4, 0, 4'hf, 32'h0);
      chk(q[5:3], 3'((s0 + inc) % 6));
   endtask
   task automatic watch(input logic lap, output int laps);
      logic [2:0] up, lo;
      logic pp, po;
      laps = 0;
      pp = pwm_n;
      po = ovc;
      repeat (200)
      begin
         @(negedge clk_i);
         up = ~{wn, vn, un};
         lo = {wl, vl, ul};
         if (pp === 1 || po === 1)
            chk(up, 3'b000);
         else if (!lap)
            chk((up & lo) == 0 && $onehot(up), 1);
         if (!lap)
            chk($onehot(lo), 1);
         if ($countones(lo) > 1)
            laps++;
         if (fq === 1)
            chk(ul, 1'b0);
         if (!lap && pp === 0 && po === 0)
            chk(fq, up[0]);
         pp = pwm_n;
         po = ovc;
      end
   endtask
   initial
   begin
      int k;
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      @(negedge clk_i);
      chk({un, vn, wn, ul, vl, wl, fq}, 7'b1110000);
      wb(4'h0, 0, 4'hf, 32'h0);
      chk(q, `SBC_CTRL_RST);
      for (int i = 0; i < 8; i++)
      begin
         wb(r_adr[i], 1, r_sel[i], r_dat[i]);
         wb(r_adr[i], 0, 4'hf, 32'h0);
         chk(q, r_exp[i]);
         chk(e, r_adr[i] == 4'hc);
      end
      run <= 1;
      wait_mode(SBC_FORCED);
      step_by(1);
      wb(4'h0, 1, 4'hf, 32'h9);
      step_by(5);
      watch(1'b0, k);
      @(posedge clk_i);
      ovc <= 1;
      wb(4'h4, 0, 4'hf, 32'h0);
      chk(q[8], 1'b1);
      watch(1'b0, k);
      @(posedge clk_i);
      ovc <= 0;
      wb(4'h0, 1, 4'hf, 32'h0);
      watch(1'b1, k);
      chk(k > 0, 1);
      wb(4'h0, 1, 4'hf, 32'ha);
      wb(4'h4, 0, 4'hf, 32'h0);
      chk(q[7:6], 2'h0);
      wb(4'h0, 1, 4'hf, 32'he);
      wb(4'h4, 0, 4'hf, 32'h0);
      chk(q[7:6], 2'h3);
      spin <= 1;
      wb(4'h0, 1, 4'hf, 32'hc);
      wait_mode(SBC_NORMAL);
      wb(4'h4, 0, 4'hf, 32'h0);
      chk(q[7:6], 2'h2);
      wb(4'h8, 0, 4'hf, 32'h0);
      chk(q > 180 && q < 220, 1);
      run <= 0;
      wait_mode(SBC_STOP);
      @(negedge clk_i);
      chk({un, vn, wn, ul, vl, wl}, 6'b111000);
      // reset after the stop must bring the control word back
      @(posedge clk_i);
      rst_i <= 1;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      wb(4'h0, 0, 4'hf, 32'h0);
      chk(q, `SBC_CTRL_RST);
      conclude();
   end
endmodule
